// file: logic/usmp_pkg.sv
`default_nettype none
package usmp_pkg;
	// ========================================
	// register byte offsets on the register bus
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_STAT_A = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_C = 5'h0C;
	localparam logic [ADDR_W-1:0] ADDR_BAUD = 5'h10;
	// ========================================
	// field positions
	localparam int SA_RXC = 7;
	localparam int SA_TXC = 6;
	localparam int SA_DATA_EMPTY_FLAG = 5;
	localparam int SA_FE = 4;
	localparam int SA_DOR = 3;
	localparam int SA_PE = 2;
	localparam int SA_ADDRESS_FILTER_ENABLE = 0;
	localparam int CB_RECEIVE_COMPLETE_IRQ_ENABLE = 7;
	localparam int CB_TRANSMIT_COMPLETE_IRQ_ENABLE = 6;
	localparam int CB_DATA_EMPTY_IRQ_ENABLE = 5;
	localparam int CB_RECEIVER_ENABLE = 4;
	localparam int CB_TRANSMITTER_ENABLE = 3;
	localparam int CB_SIZE_HI = 2;
	localparam int CB_RECEIVE_NINTH_BIT = 1;
	localparam int CB_TRANSMIT_NINTH_BIT = 0;
	localparam int CC_PAR_EN = 5;
	localparam int CC_PAR_ODD = 4;
	localparam int CC_STOP2 = 3;
	localparam int CC_SIZE_LO = 1;
	localparam logic [7:0] CTRL_C_MASK = 8'h3E;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam logic [7:0] CTRL_C_RESET = 8'h06;
	// ========================================
	// frame and bus constants
	localparam int BAUD_W = 12;
	localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h01F;
	localparam logic [3:0] CHAR_MIN_BITS = 4'h5;
	localparam logic [3:0] EIGHT_BITS = 4'h8;
	localparam logic [3:0] NINE_BITS = 4'h9;
	localparam logic [2:0] SIZE_NINE = 3'h7;
	localparam int FIFO_DEPTH = 8;
	localparam int RX_WORD_W = 11;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {LS_IDLE, LS_START, LS_DATA, LS_PAR, LS_STOP} usmp_line_state_t;
	// data bits per character from the size code; code 7 is the nine-bit frame
	function automatic logic [3:0] usmp_data_bits(input logic [2:0] code);
		if (code == SIZE_NINE) begin
			return NINE_BITS;
		end else if (!code[2]) begin
			return CHAR_MIN_BITS + {2'h0, code[1:0]};
		end
		return EIGHT_BITS;
	endfunction : usmp_data_bits
	// word decode shared by read and write paths; 3'h7 means unmapped
	function automatic logic [2:0] usmp_reg_index(input logic [ADDR_W-1:0] addr);
		case ({addr[ADDR_W-1:2], 2'h0})
			ADDR_DATA: return 3'h0;
			ADDR_STAT_A: return 3'h1;
			ADDR_CTRL_B: return 3'h2;
			ADDR_CTRL_C: return 3'h3;
			ADDR_BAUD: return 3'h4;
			default: return 3'h7;
		endcase
	endfunction : usmp_reg_index
endpackage : usmp_pkg
`default_nettype wire

// file: logic/usmp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module usmp_fifo import usmp_pkg::*; #(
	parameter int WIDTH = RX_WORD_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic flush_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic push, pop;
	// ========================================
	// pointers carry one extra bit so full and empty differ
	assign in_ready_o = (wr_ptr_reg - rd_ptr_reg) != (PW+1)'(DEPTH);
	assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
	assign out_data_o = mem[rd_ptr_reg[PW-1:0]];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_comb begin
		wr_ptr_next = wr_ptr_reg + (PW+1)'(push);
		rd_ptr_next = rd_ptr_reg + (PW+1)'(pop);
		if (flush_i) begin
			wr_ptr_next = '0;
			rd_ptr_next = '0;
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
		end
	end
	// storage needs no reset; the pointers say what is valid
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_reg[PW-1:0]] <= in_data_i;
		end
	end
endmodule : usmp_fifo
`default_nettype wire

// file: logic/usmp_rx_deser.sv
`timescale 1ns/1ps
`default_nettype none
module usmp_rx_deser import usmp_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// configuration and serial input
	input wire logic enable_i,
	input wire logic rxd_i,
	input wire logic [3:0] bits_i,
	input wire logic par_en_i,
	input wire logic par_odd_i,
	input wire logic [BAUD_W-1:0] baud_i,
	// received frame
	output logic done_o,
	output logic [8:0] data_o,
	output logic ftype_o,
	output logic ferr_o,
	output logic perr_o
);
	usmp_line_state_t st_reg, st_next;
	logic [BAUD_W-1:0] cnt_reg, cnt_next;
	logic [3:0] idx_reg, idx_next;
	logic [8:0] sh_reg, sh_next;
	logic par_reg, par_next;
	logic done_next, ftype_next, ferr_next, perr_next;
	logic [8:0] data_next;
	logic tick;
	// ========================================
	// bit timing: one bit lasts baud_i+1 cycles, sampled mid-bit
	assign tick = cnt_reg == '0;
	always_comb begin
		st_next = st_reg;
		cnt_next = tick ? baud_i : cnt_reg - 1'b1;
		idx_next = idx_reg;
		sh_next = sh_reg;
		par_next = par_reg;
		done_next = 1'b0;
		data_next = data_o;
		ftype_next = ftype_o;
		ferr_next = ferr_o;
		perr_next = perr_o;
		case (st_reg)
			LS_IDLE: begin
				cnt_next = baud_i >> 1;
				if (!rxd_i) begin
					st_next = LS_START;
				end
			end
			LS_START: if (tick) begin
				// a glitch shorter than half a bit is not a start
				st_next = rxd_i ? LS_IDLE : LS_DATA;
				idx_next = '0;
				sh_next = '0;
			end
			LS_DATA: if (tick) begin
				sh_next[idx_reg] = rxd_i;
				idx_next = idx_reg + 1'b1;
				if (idx_reg == bits_i - 1'b1) begin
					st_next = par_en_i ? LS_PAR : LS_STOP;
				end
			end
			LS_PAR: if (tick) begin
				par_next = rxd_i;
				st_next = LS_STOP;
			end
			LS_STOP: if (tick) begin
				st_next = LS_IDLE;
				done_next = 1'b1;
				data_next = sh_reg;
				ftype_next = (bits_i == NINE_BITS) ? sh_reg[8] : rxd_i;
				ferr_next = !rxd_i;
				perr_next = par_en_i && (^sh_reg ^ par_reg ^ par_odd_i);
			end
			default: st_next = LS_IDLE;
		endcase
		if (!enable_i) begin
			st_next = LS_IDLE;
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= LS_IDLE;
			cnt_reg <= '0;
			idx_reg <= '0;
			sh_reg <= '0;
			par_reg <= 1'b0;
			done_o <= 1'b0;
			data_o <= '0;
			ftype_o <= 1'b0;
			ferr_o <= 1'b0;
			perr_o <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			sh_reg <= sh_next;
			par_reg <= par_next;
			done_o <= done_next;
			data_o <= data_next;
			ftype_o <= ftype_next;
			ferr_o <= ferr_next;
			perr_o <= perr_next;
		end
	end
	chk_frame_type_pick: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_reg == LS_STOP && tick && enable_i && bits_i == NINE_BITS) |=> done_o && ftype_o == data_o[8])
		else $error("nine-bit frame type not taken from ninth bit");
endmodule : usmp_rx_deser
`default_nettype wire

// file: logic/usmp_core.sv
// What this block does
// - filter on: drop frames without address
// - frame type: first stop, or ninth bit
// - type one is address, zero is data
// - transmitter ignores the filter setting
// - accepted address frame sets receive-complete normally
// - receive irq needs enable, global, flag
// - transmit irq needs enable, global, flag
// - empty irq needs enable, global, flag
// - receiver enable owns pin; off flushes errors
// - transmitter off waits until fully drained
// - size high bit joins low size bits
// - ninth received bit readable, read it first
`timescale 1ns/1ps
`default_nettype none
module usmp_core import usmp_pkg::*; (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// serial line
	input wire logic RXD_I,
	output logic RXD_OWN_O,
	output logic TXD_O,
	output logic TXD_OE_O,
	// global interrupt enable and interrupt requests
	input wire logic GLOBAL_IRQ_EN_I,
	output logic IRQ_RX_DONE_O,
	output logic IRQ_TX_DONE_O,
	output logic IRQ_DATA_EMPTY_O
);
	// ========================================
	// register state
	logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic address_filter_enable_reg, address_filter_enable_next, txc_reg, txc_next, dor_reg, dor_next;
	logic [7:0] ctrl_b_reg, ctrl_b_next, ctrl_c_reg, ctrl_c_next;
	logic [BAUD_W-1:0] baud_reg, baud_next;
	logic [8:0] txbuf_reg, txbuf_next;
	logic txbuf_full_reg, txbuf_full_next;
	logic rxd_meta_reg, rxd_sync_reg;
	// receive path and bus wires
	logic rx_done, rx_ftype, rx_ferr, rx_perr, rx_accept, fifo_in_ready, fifo_out_valid, rd_pop;
	logic [8:0] rx_data;
	logic [RX_WORD_W-1:0] fifo_head;
	logic [3:0] char_bits;
	logic wr_go, ar_go;
	logic [2:0] wr_idx, rd_idx;
	logic [7:0] stat_a_view, ctrl_b_view;
	// transmit path state
	usmp_line_state_t tx_st_reg, tx_st_next;
	logic [BAUD_W-1:0] tx_cnt_reg, tx_cnt_next;
	logic [3:0] tx_idx_reg, tx_idx_next;
	logic [8:0] tx_sh_reg, tx_sh_next;
	logic tx_par_reg, tx_par_next, txd_reg, txd_next, tx_own_reg, tx_own_next;
	logic tx_load, tx_end, tx_tick;
	// ========================================
	// receive pin passes two flops before any logic looks at it
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
		end else begin
			rxd_meta_reg <= RXD_I;
			rxd_sync_reg <= rxd_meta_reg;
		end
	end
	// size code is shared by both directions
	assign char_bits = usmp_data_bits({ctrl_b_reg[CB_SIZE_HI], ctrl_c_reg[CC_SIZE_LO +: 2]});
	usmp_rx_deser u_rx (
		.clk_i(CLK_SYS_I),
		.rst_b_i(RST_B_I),
		.enable_i(ctrl_b_reg[CB_RECEIVER_ENABLE]),
		.rxd_i(rxd_sync_reg),
		.bits_i(char_bits),
		.par_en_i(ctrl_c_reg[CC_PAR_EN]),
		.par_odd_i(ctrl_c_reg[CC_PAR_ODD]),
		.baud_i(baud_reg),
		.done_o(rx_done),
		.data_o(rx_data),
		.ftype_o(rx_ftype),
		.ferr_o(rx_ferr),
		.perr_o(rx_perr)
	);
	// ========================================
	// frame filter: with filtering on only address frames reach the buffer
	assign rx_accept = rx_done && ctrl_b_reg[CB_RECEIVER_ENABLE] && (!address_filter_enable_reg || rx_ftype);
	// the serial line cannot wait, so a full buffer shows up as overrun
	usmp_fifo #(.WIDTH(RX_WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_i(CLK_SYS_I),
		.rst_b_i(RST_B_I),
		.flush_i(!ctrl_b_reg[CB_RECEIVER_ENABLE]),
		.in_valid_i(rx_accept),
		.in_ready_o(fifo_in_ready),
		.in_data_i({rx_perr, rx_ferr, rx_data}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(rd_pop),
		.out_data_o(fifo_head)
	);
	// ========================================
	// bus handshakes and register views
	assign S_AXI_AWREADY_O = !aw_got_reg && !bvalid_reg;
	assign S_AXI_WREADY_O = !w_got_reg && !bvalid_reg;
	assign S_AXI_ARREADY_O = !rvalid_reg;
	assign S_AXI_BVALID_O = bvalid_reg;
	assign S_AXI_BRESP_O = bresp_reg;
	assign S_AXI_RVALID_O = rvalid_reg;
	assign S_AXI_RDATA_O = rdata_reg;
	assign S_AXI_RRESP_O = rresp_reg;
	assign wr_go = aw_got_reg && w_got_reg && !bvalid_reg;
	assign ar_go = S_AXI_ARVALID_I && !rvalid_reg;
	assign wr_idx = usmp_reg_index(aw_addr_reg);
	assign rd_idx = usmp_reg_index(S_AXI_ARADDR_I);
	assign rd_pop = ar_go && rd_idx == 3'h0 && fifo_out_valid;
	// error flags belong to the character at the head of the buffer
	always_comb begin
		stat_a_view = '0;
		stat_a_view[SA_RXC] = fifo_out_valid;
		stat_a_view[SA_TXC] = txc_reg;
		stat_a_view[SA_DATA_EMPTY_FLAG] = !txbuf_full_reg;
		stat_a_view[SA_FE] = fifo_out_valid && fifo_head[9];
		stat_a_view[SA_DOR] = dor_reg;
		stat_a_view[SA_PE] = fifo_out_valid && fifo_head[10];
		stat_a_view[SA_ADDRESS_FILTER_ENABLE] = address_filter_enable_reg;
		ctrl_b_view = ctrl_b_reg;
		ctrl_b_view[CB_RECEIVE_NINTH_BIT] = fifo_out_valid && fifo_head[8];
	end
	// register file next state; every hardware set beats a software clear
	always_comb begin
		aw_got_next = aw_got_reg || (S_AXI_AWVALID_I && S_AXI_AWREADY_O);
		aw_addr_next = (S_AXI_AWVALID_I && S_AXI_AWREADY_O) ? S_AXI_AWADDR_I : aw_addr_reg;
		w_got_next = w_got_reg || (S_AXI_WVALID_I && S_AXI_WREADY_O);
		w_data_next = (S_AXI_WVALID_I && S_AXI_WREADY_O) ? S_AXI_WDATA_I : w_data_reg;
		w_strb_next = (S_AXI_WVALID_I && S_AXI_WREADY_O) ? S_AXI_WSTRB_I : w_strb_reg;
		bvalid_next = bvalid_reg && !S_AXI_BREADY_I;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg && !S_AXI_RREADY_I;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		address_filter_enable_next = address_filter_enable_reg;
		ctrl_b_next = ctrl_b_reg;
		ctrl_c_next = ctrl_c_reg;
		baud_next = baud_reg;
		txbuf_next = txbuf_reg;
		txbuf_full_next = txbuf_full_reg && !tx_load;
		txc_next = txc_reg;
		dor_next = dor_reg && !rd_pop;
		if (wr_go) begin
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (wr_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
			if (w_strb_reg[0]) begin
				case (wr_idx)
					3'h0: if (!txbuf_full_reg) begin
						// a write while the buffer is full is dropped
						txbuf_next = {ctrl_b_reg[CB_TRANSMIT_NINTH_BIT], w_data_reg[7:0]};
						txbuf_full_next = 1'b1;
					end
					3'h1: begin
						address_filter_enable_next = w_data_reg[SA_ADDRESS_FILTER_ENABLE];
						// write one clears; a plain byte write is safe here
						if (w_data_reg[SA_TXC]) begin
							txc_next = 1'b0;
						end
					end
					3'h2: ctrl_b_next = w_data_reg[7:0] & ~(8'h01 << CB_RECEIVE_NINTH_BIT);
					3'h3: ctrl_c_next = w_data_reg[7:0] & CTRL_C_MASK;
					3'h4: baud_next[7:0] = w_data_reg[7:0];
					default: ;
				endcase
			end
			if (w_strb_reg[1] && wr_idx == 3'h4) begin
				baud_next[BAUD_W-1:8] = w_data_reg[BAUD_W-1:8];
			end
		end
		if (ar_go) begin
			rvalid_next = 1'b1;
			rresp_next = (rd_idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
			case (rd_idx)
				3'h0: rdata_next = {24'h000000, fifo_head[7:0] & {8{fifo_out_valid}}};
				3'h1: rdata_next = {24'h000000, stat_a_view};
				3'h2: rdata_next = {24'h000000, ctrl_b_view};
				3'h3: rdata_next = {24'h000000, ctrl_c_reg};
				3'h4: rdata_next = {{(32-BAUD_W){1'b0}}, baud_reg};
				default: rdata_next = '0;
			endcase
		end
		if (tx_end) begin
			txc_next = 1'b1;
		end
		if (rx_accept && !fifo_in_ready) begin
			dor_next = 1'b1;
		end
		if (!ctrl_b_reg[CB_RECEIVER_ENABLE]) begin
			dor_next = 1'b0;
		end
	end
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			aw_got_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_got_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= '0;
			address_filter_enable_reg <= 1'b0;
			ctrl_b_reg <= CTRL_B_RESET;
			ctrl_c_reg <= CTRL_C_RESET;
			baud_reg <= BAUD_RESET;
			txbuf_reg <= '0;
			txbuf_full_reg <= 1'b0;
			txc_reg <= 1'b0;
			dor_reg <= 1'b0;
		end else begin
			aw_got_reg <= aw_got_next;
			aw_addr_reg <= aw_addr_next;
			w_got_reg <= w_got_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			address_filter_enable_reg <= address_filter_enable_next;
			ctrl_b_reg <= ctrl_b_next;
			ctrl_c_reg <= ctrl_c_next;
			baud_reg <= baud_next;
			txbuf_reg <= txbuf_next;
			txbuf_full_reg <= txbuf_full_next;
			txc_reg <= txc_next;
			dor_reg <= dor_next;
		end
	end
	// ========================================
	// transmitter; the filter bit never enters this path
	assign tx_tick = tx_cnt_reg == '0;
	assign tx_load = tx_st_reg == LS_IDLE && tx_own_reg && txbuf_full_reg;
	assign tx_end = tx_st_reg == LS_STOP && tx_tick && tx_idx_reg == '0 && !txbuf_full_reg;
	always_comb begin
		tx_st_next = tx_st_reg;
		tx_cnt_next = tx_tick ? baud_reg : tx_cnt_reg - 1'b1;
		tx_idx_next = tx_idx_reg;
		tx_sh_next = tx_sh_reg;
		tx_par_next = tx_par_reg;
		txd_next = 1'b1;
		case (tx_st_reg)
			LS_IDLE: if (tx_load) begin
				tx_st_next = LS_START;
				tx_sh_next = txbuf_reg;
				tx_par_next = ^(txbuf_reg & ~(9'h1FF << char_bits)) ^ ctrl_c_reg[CC_PAR_ODD];
				tx_cnt_next = baud_reg;
				tx_idx_next = '0;
				txd_next = 1'b0;
			end
			LS_START: begin
				txd_next = 1'b0;
				if (tx_tick) begin
					tx_st_next = LS_DATA;
					txd_next = tx_sh_reg[0];
				end
			end
			LS_DATA: begin
				txd_next = tx_sh_reg[0];
				if (tx_tick) begin
					tx_sh_next = tx_sh_reg >> 1;
					tx_idx_next = tx_idx_reg + 1'b1;
					txd_next = tx_sh_reg[1];
					if (tx_idx_reg == char_bits - 1'b1) begin
						tx_st_next = ctrl_c_reg[CC_PAR_EN] ? LS_PAR : LS_STOP;
						txd_next = ctrl_c_reg[CC_PAR_EN] ? tx_par_reg : 1'b1;
						tx_idx_next = {3'h0, ctrl_c_reg[CC_STOP2]};
					end
				end
			end
			LS_PAR: begin
				txd_next = tx_par_reg;
				if (tx_tick) begin
					tx_st_next = LS_STOP;
					txd_next = 1'b1;
				end
			end
			LS_STOP: if (tx_tick) begin
				// second stop bit repeats this state once
				tx_idx_next = tx_idx_reg - 1'b1;
				if (tx_idx_reg == '0) begin
					tx_st_next = LS_IDLE;
				end
			end
			default: tx_st_next = LS_IDLE;
		endcase
		// pin stays owned until shifter and buffer are both empty
		tx_own_next = ctrl_b_reg[CB_TRANSMITTER_ENABLE] ||
			(tx_own_reg && (tx_st_next != LS_IDLE || txbuf_full_reg));
	end
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			tx_st_reg <= LS_IDLE;
			tx_cnt_reg <= '0;
			tx_idx_reg <= '0;
			tx_sh_reg <= '0;
			tx_par_reg <= 1'b0;
			txd_reg <= 1'b1;
			tx_own_reg <= 1'b0;
		end else begin
			tx_st_reg <= tx_st_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_idx_reg <= tx_idx_next;
			tx_sh_reg <= tx_sh_next;
			tx_par_reg <= tx_par_next;
			txd_reg <= txd_next;
			tx_own_reg <= tx_own_next;
		end
	end
	// ========================================
	// pins and interrupt requests
	assign TXD_O = txd_reg;
	assign TXD_OE_O = tx_own_reg;
	assign RXD_OWN_O = ctrl_b_reg[CB_RECEIVER_ENABLE];
	assign IRQ_RX_DONE_O = ctrl_b_reg[CB_RECEIVE_COMPLETE_IRQ_ENABLE] && GLOBAL_IRQ_EN_I && fifo_out_valid;
	assign IRQ_TX_DONE_O = ctrl_b_reg[CB_TRANSMIT_COMPLETE_IRQ_ENABLE] && GLOBAL_IRQ_EN_I && txc_reg;
	assign IRQ_DATA_EMPTY_O = ctrl_b_reg[CB_DATA_EMPTY_IRQ_ENABLE] && GLOBAL_IRQ_EN_I && !txbuf_full_reg;
	// ========================================
	// checks
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_B_I);
	sequence s_data_frame_filtered;
		rx_done && address_filter_enable_reg && !rx_ftype;
	endsequence
	chk_filter_drops_data: assert property (s_data_frame_filtered ##0 !fifo_out_valid |=> !fifo_out_valid)
		else $error("filtered data frame reached the buffer");
	chk_address_accepted: assert property (rx_done && rx_ftype && ctrl_b_reg[CB_RECEIVER_ENABLE] && fifo_in_ready |=> fifo_out_valid)
		else $error("address frame not accepted");
	chk_rx_irq_gate: assert property (IRQ_RX_DONE_O |-> GLOBAL_IRQ_EN_I && stat_a_view[SA_RXC] && ctrl_b_reg[CB_RECEIVE_COMPLETE_IRQ_ENABLE])
		else $error("receive irq without all causes");
	chk_tx_irq_gate: assert property ($rose(txc_reg) && ctrl_b_reg[CB_TRANSMIT_COMPLETE_IRQ_ENABLE] && GLOBAL_IRQ_EN_I |-> IRQ_TX_DONE_O)
		else $error("transmit irq missing");
	chk_empty_irq_gate: assert property ($fell(txbuf_full_reg) && ctrl_b_reg[CB_DATA_EMPTY_IRQ_ENABLE] && GLOBAL_IRQ_EN_I |-> IRQ_DATA_EMPTY_O)
		else $error("empty irq missing");
	chk_rx_off_flush: assert property ($fell(ctrl_b_reg[CB_RECEIVER_ENABLE]) |=> !fifo_out_valid && !dor_reg && !RXD_OWN_O)
		else $error("receiver disable did not flush");
	chk_tx_off_drain: assert property ($fell(TXD_OE_O) |-> tx_st_reg == LS_IDLE && !txbuf_full_reg && !ctrl_b_reg[CB_TRANSMITTER_ENABLE])
		else $error("transmit pin released early");
	chk_tx_load_copy: assert property (tx_load |=> tx_sh_reg == $past(txbuf_reg) ##1 1'b1)
		else $error("shifter did not take the buffer");
endmodule : usmp_core
`default_nettype wire

// file: test/usmp_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module usmp_line_model (
	// serial line toward the device
	input wire logic clk_i,
	output logic rxd_o
);
	// bit time must equal the baud register plus one
	int bit_clks = 4;
	// line idles high, as with a pull-up, whenever no frame is sent
	initial rxd_o = 1'b1;
	task automatic put(input logic b);
		rxd_o <= b;
		repeat (bit_clks) @(posedge clk_i);
	endtask : put
	// start, data lsb first, frame type (a plain stop for nine bits), closing stop; bit 8 of d is the type
	task automatic send(input logic [8:0] d, input int nbits);
		put(1'b0);
		for (int i = 0; i < nbits; i++) put(d[i]);
		put(nbits == 9 ? 1'b1 : d[8]);
		put(1'b1);
		// one idle bit time lets the receiver finish its buffer write before software looks
		repeat (bit_clks) @(posedge clk_i);
	endtask : send
endmodule : usmp_line_model
`default_nettype wire

// file: test/usmp_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module usmp_core_test import usmp_pkg::*;;
	// ====
	// signals
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic gie = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [ADDR_W-1:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, rxd_own, txd, txd_oe, irq_rx, irq_tx, irq_de;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] rv;
	wire rxd;
	int n_errors = 0;
	int n_checks = 0;
	// ====
	// device and far-side line
	always #2.5 clk = ~clk;
	usmp_line_model u_line (.clk_i(clk), .rxd_o(rxd));
	usmp_core u_dut (
		.CLK_SYS_I(clk), .RST_B_I(rst_b),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
		.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .RXD_I(rxd),
		.RXD_OWN_O(rxd_own), .TXD_O(txd), .TXD_OE_O(txd_oe), .GLOBAL_IRQ_EN_I(gie),
		.IRQ_RX_DONE_O(irq_rx), .IRQ_TX_DONE_O(irq_tx), .IRQ_DATA_EMPTY_O(irq_de)
	);
	// ====
	// tasks
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// each channel drops valid at its own handshake; one idle edge keeps bready single-driven
	task automatic axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {6'h00, bresp}, {6'h00, er});
		@(posedge clk);
	endtask : axw
	task automatic axr(input logic [4:0] a, output logic [7:0] d, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata[7:0];
		chk("rresp", {6'h00, rresp}, {6'h00, er});
		@(posedge clk);
	endtask : axr
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] d;
		axr(a, d, RESP_OKAY);
		chk("rdata", d, exp);
	endtask : rd
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// ====
	// watchdog: the whole sequence needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
	// ====
	// tests
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(ADDR_CTRL_B, 8'h00);
		rd(ADDR_CTRL_C, 8'h06);
		rd(ADDR_STAT_A, 8'h20);
		chk("txd_oe", txd_oe, 1'b0);
		axr(5'h14, rv, RESP_SLVERR);
		chk("rdata", rv, 8'h00);
		axw(5'h18, 8'hFF, RESP_SLVERR);
		// nine-bit slave, filter on: data dropped, address kept
		axw(ADDR_BAUD, 8'h03, RESP_OKAY);
		axw(ADDR_CTRL_B, 8'h14, RESP_OKAY);
		axw(ADDR_STAT_A, 8'h01, RESP_OKAY);
		chk("rxd_own", rxd_own, 1'b1);
		u_line.send(9'h055, 9);
		rd(ADDR_STAT_A, 8'h21);
		u_line.send(9'h1A3, 9);
		rd(ADDR_STAT_A, 8'hA1);
		rd(ADDR_CTRL_B, 8'h16);
		rd(ADDR_DATA, 8'hA3);
		// filter off: data frames fill the buffer past its depth
		axw(ADDR_STAT_A, 8'h00, RESP_OKAY);
		for (int i = 0; i <= FIFO_DEPTH; i++) u_line.send(9'(i), 9);
		rd(ADDR_STAT_A, 8'hA8);
		rd(ADDR_CTRL_B, 8'h14);
		for (int i = 0; i < FIFO_DEPTH; i++) rd(ADDR_DATA, 8'(i));
		rd(ADDR_STAT_A, 8'h20);
		// eight-bit frames: first stop gives the type
		axw(ADDR_STAT_A, 8'h01, RESP_OKAY);
		axw(ADDR_CTRL_B, 8'h90, RESP_OKAY);
		u_line.send(9'h03C, 8);
		rd(ADDR_STAT_A, 8'h21);
		u_line.send(9'h1C3, 8);
		chk("irq_rx", irq_rx, 1'b0);
		gie <= 1'b1;
		@(posedge clk);
		chk("irq_rx", irq_rx, 1'b1);
		// receiver off flushes the waiting frame
		axw(ADDR_CTRL_B, 8'h20, RESP_OKAY);
		rd(ADDR_STAT_A, 8'h21);
		chk("rxd_own", rxd_own, 1'b0);
		chk("irq_rx", irq_rx, 1'b0);
		chk("irq_de", irq_de, 1'b1);
		gie <= 1'b0;
		@(posedge clk);
		chk("irq_de", irq_de, 1'b0);
		gie <= 1'b1;
		// transmit with the filter still on; disable waits for the drain
		axw(ADDR_CTRL_B, 8'h48, RESP_OKAY);
		chk("txd_oe", txd_oe, 1'b1);
		axw(ADDR_DATA, 8'h5A, RESP_OKAY);
		chk("txd", txd, 1'b0);
		axw(ADDR_CTRL_B, 8'h40, RESP_OKAY);
		chk("txd_oe", txd_oe, 1'b1);
		do axr(ADDR_STAT_A, rv, RESP_OKAY); while (rv[SA_TXC] !== 1'b1);
		chk("txd_oe", txd_oe, 1'b0);
		chk("irq_tx", irq_tx, 1'b1);
		chk("txd", txd, 1'b1);
		axw(ADDR_STAT_A, 8'h41, RESP_OKAY);
		rd(ADDR_STAT_A, 8'h21);
		chk("irq_tx", irq_tx, 1'b0);
		print_verdict();
	end
endmodule : usmp_core_test
`default_nettype wire
